// >>> rtl/drdac_params.svh
// Constants for the direct-register output update block.
// Assumes inclusion by the package, the design module and the bench.
`ifndef DRDAC_PARAMS_SVH
`define DRDAC_PARAMS_SVH
// Register byte offsets
`define DRDAC_OFF_CTRL 12'h000
`define DRDAC_OFF_CH0 12'h008
`define DRDAC_OFF_CH1 12'h00c
`define DRDAC_OFF_BOW 12'h03c
`define DRDAC_OFF_STAT 12'h040
// Control word and role register field positions
`define DRDAC_CTL_BUFSEL 0
`define DRDAC_CTL_SIMUL 1
`define DRDAC_CTL_SWCLK 2
`define DRDAC_CTL_RATEC_EN 3
`define DRDAC_CTL_RANGE_LO 4
`define DRDAC_CTL_RANGE_HI 5
`define DRDAC_BOW_INIT 0
// Reset values
`define DRDAC_CODE_RST 16'h8000
`define DRDAC_RANGE_RST 2'h0
// Output clock pulse width, system clock period, code width and channel count
`define DRDAC_PULSE_NS 100
`define DRDAC_CLK_NS 100
`define DRDAC_PULSE_CYC ((`DRDAC_PULSE_NS + `DRDAC_CLK_NS - 1) / `DRDAC_CLK_NS)
`define DRDAC_CODE_W 16
`define DRDAC_CH_N 2
`endif

// >>> rtl/drdac_pkg.sv
// Types for the direct-register output update block.
// Assumes the constants header is on the include path.
`include "drdac_params.svh"
package drdac_pkg;
    // Output span selection
    typedef enum logic [1:0] {DRDAC_SPAN_10V = 2'h0, DRDAC_SPAN_5V = 2'h1, DRDAC_SPAN_2V5 = 2'h2} drdac_span_t;
    // APB request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } drdac_apb_req_t;
    // Analog output bundle
    typedef struct packed {
        logic [15:0] code0;
        logic [15:0] code1;
        drdac_span_t span;
    } drdac_aout_t;
endpackage

// >>> rtl/drdac_core.sv
// Direct-register update logic for two analog output channels with APB access.
// Assumes sys_clk at 10 MHz, synchronous reset, and a peer-driven shared clock pin.
//
// Functional notes
// - With buffered select low, both outputs come only from the channel data registers.
// - With buffered select high, the buffered path owns the outputs and direct registers do not.
// - Each channel has a holding register and an output register.
// - Codes are right-justified 16-bit values that reset to midscale 0x8000.
// - Bits 16 to 31 of a data register write are ignored.
// - A span field chooses 10V, 5V or 2.5V and resets to 10V.
// - With joint update low, a write moves the channel code to its output at once.
// - With joint update high, outputs hold until an output clock loads all channels together.
// - In joint mode a software strobe write is an output clock regardless of other settings.
// - The third rate generator clocks outputs only when enabled and the role is initiator.
// - In joint mode as target, output clocks come from the external pin.
// - As initiator the pin is driven with one 100 ns low pulse per output clock.
// - As target the pin is released and each received falling edge is one output clock.
// - As target the third rate generator pulses are ignored.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "drdac_params.svh"
module drdac_core
    import drdac_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Rate generator pulse and buffered path codes
    input wire logic ratec_tick,
    input wire logic [15:0] buf_code0,
    input wire logic [15:0] buf_code1,
    // Shared output clock pin
    input wire logic oclk_in,
    output logic oclk_out,
    output logic oclk_oe,
    // Analog outputs
    output drdac_aout_t aout,
    output logic out_clk_event
);
    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    drdac_apb_req_t req;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    wire access_w = req.psel && req.penable;
    wire wr_w = access_w && req.pwrite;
    wire hit_ctrl = req.paddr == `DRDAC_OFF_CTRL;
    wire hit_ch0 = req.paddr == `DRDAC_OFF_CH0;
    wire hit_ch1 = req.paddr == `DRDAC_OFF_CH1;
    wire hit_bow = req.paddr == `DRDAC_OFF_BOW;
    wire hit_stat = req.paddr == `DRDAC_OFF_STAT;
    wire mapped_w = hit_ctrl || hit_ch0 || hit_ch1 || hit_bow || hit_stat;
    wire wr_ctrl = wr_w && hit_ctrl;
    wire wr_ch0 = wr_w && hit_ch0;
    wire wr_ch1 = wr_w && hit_ch1;
    wire wr_bow = wr_w && hit_bow;
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access_w && !mapped_w;

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    logic bufsel_r;
    logic simul_r;
    logic ratec_en_r;
    logic init_r;
    logic swclk_r;
    drdac_span_t span_r;
    logic [15:0] hold0_r;
    logic [15:0] hold1_r;
    logic [15:0] out0_r;
    logic [15:0] out1_r;
    logic oclk_event_r;

    // Control word; the strobe lives one cycle only so each write of one gives one event
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            bufsel_r <= 1'b0;
            simul_r <= 1'b0;
            ratec_en_r <= 1'b0;
            span_r <= DRDAC_SPAN_10V;
            swclk_r <= 1'b0;
        end
        else
        begin
            swclk_r <= wr_ctrl && req.pwdata[`DRDAC_CTL_SWCLK];
            if (wr_ctrl)
            begin
                bufsel_r <= req.pwdata[`DRDAC_CTL_BUFSEL];
                simul_r <= req.pwdata[`DRDAC_CTL_SIMUL];
                ratec_en_r <= req.pwdata[`DRDAC_CTL_RATEC_EN];
                span_r <= drdac_span_t'(req.pwdata[`DRDAC_CTL_RANGE_HI:`DRDAC_CTL_RANGE_LO]);
            end
        end
    end

    // Role bit; default target so boards never fight over the pin
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            init_r <= 1'b0;
        else if (wr_bow)
            init_r <= req.pwdata[`DRDAC_BOW_INIT];
    end

    // ---------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ---------------------------------------------------------------
    logic [2:0] pin_sync_r;
    logic pin_stable_r;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pin_sync_r <= 3'h7;
            pin_stable_r <= 1'b1;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[1:0], oclk_in};
            if (pin_sync_r[1] == pin_sync_r[2])
                pin_stable_r <= pin_sync_r[2];
        end
    end
    // Change counts only once the later two stages agree
    wire pin_agree = pin_sync_r[1] == pin_sync_r[2];
    wire pin_fall = pin_agree && pin_stable_r && !pin_sync_r[2];

    // ---------------------------------------------------------------
    // Output clock source selection
    // ---------------------------------------------------------------
    wire gen_clk = ratec_tick && ratec_en_r && init_r;
    wire ext_clk = pin_fall && !init_r;
    wire out_clk = simul_r && (swclk_r || gen_clk || ext_clk);
    assign out_clk_event = out_clk;

    // ---------------------------------------------------------------
    // Double-buffered channel data
    // ---------------------------------------------------------------
    wire [15:0] wcode = req.pwdata[`DRDAC_CODE_W-1:0];
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            hold0_r <= `DRDAC_CODE_RST;
            hold1_r <= `DRDAC_CODE_RST;
        end
        else
        begin
            if (wr_ch0)
                hold0_r <= wcode;
            if (wr_ch1)
                hold1_r <= wcode;
        end
    end

    // Output registers: immediate on write, or all at once on an output clock
    wire ld0 = simul_r ? out_clk : wr_ch0;
    wire ld1 = simul_r ? out_clk : wr_ch1;
    wire [15:0] nxt0 = simul_r ? hold0_r : wcode;
    wire [15:0] nxt1 = simul_r ? hold1_r : wcode;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            out0_r <= `DRDAC_CODE_RST;
            out1_r <= `DRDAC_CODE_RST;
        end
        else
        begin
            if (ld0)
                out0_r <= nxt0;
            if (ld1)
                out1_r <= nxt1;
        end
    end

    // Drive analog bundle; buffered path takes over when selected
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            aout <= '{code0: `DRDAC_CODE_RST, code1: `DRDAC_CODE_RST, span: DRDAC_SPAN_10V};
        else
            aout <= '{code0: bufsel_r ? buf_code0 : out0_r,
                      code1: bufsel_r ? buf_code1 : out1_r,
                      span: span_r};
    end

    // ---------------------------------------------------------------
    // Initiator pin pulse
    // ---------------------------------------------------------------
    logic [1:0] pulse_cnt_r;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pulse_cnt_r <= 2'h0;
        else if (out_clk && init_r)
            pulse_cnt_r <= 2'(`DRDAC_PULSE_CYC);
        else if (pulse_cnt_r != 2'h0)
            pulse_cnt_r <= pulse_cnt_r - 2'h1;
    end
    // Registered pin drive keeps the low pulse glitch free
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            oclk_out <= 1'b1;
            oclk_oe <= 1'b0;
            oclk_event_r <= 1'b0;
        end
        else
        begin
            oclk_oe <= init_r;
            // Counter stretches the low level should the pulse ever span more than one clock
            oclk_out <= !((out_clk && init_r) || pulse_cnt_r > 2'h1);
            oclk_event_r <= out_clk;
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    wire [31:0] ctrl_rd = {26'h0, span_r, ratec_en_r, 1'b0, simul_r, bufsel_r};
    wire [31:0] stat_rd = {29'h0, oclk_event_r, pin_stable_r, init_r};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         hit_ch0 ? {16'h0, hold0_r} :
                         hit_ch1 ? {16'h0, hold1_r} :
                         hit_bow ? {31'h0, init_r} :
                         hit_stat ? stat_rd : 32'h0;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            prdata <= 32'h0;
        else if (req.psel && !req.penable)
            prdata <= rd_mux;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    direct_mode_out_a: assert property (!bufsel_r |=> aout.code0 == $past(out0_r))
        else $error("direct output differs from channel register");
    buffered_mode_out_a: assert property (bufsel_r |=> aout.code1 == $past(buf_code1))
        else $error("buffered code not passed");
    hold_reg_load_a: assert property (wr_ch0 |=> hold0_r == $past(req.pwdata[15:0]))
        else $error("holding register not loaded");
    upper_bits_a: assert property (wr_ch1 |=> hold1_r[15:0] == $past(pwdata[15:0]))
        else $error("upper bits affected code");
    immediate_upd_a: assert property (wr_ch0 && !simul_r |=> out0_r == $past(pwdata[15:0]))
        else $error("immediate update missed");
    joint_hold_a: assert property (simul_r && !out_clk |=> out0_r == $past(out0_r) && out1_r == $past(out1_r))
        else $error("output changed without clock");
    joint_load_a: assert property (out_clk |=> out0_r == $past(hold0_r) && out1_r == $past(hold1_r))
        else $error("joint load wrong");
    sw_strobe_a: assert property (wr_ctrl && pwdata[`DRDAC_CTL_SWCLK] && simul_r && pwdata[`DRDAC_CTL_SIMUL]
                                  |=> out_clk ##1 !swclk_r)
        else $error("software strobe lost");
    target_gen_a: assert property (!init_r && !pin_fall && !swclk_r |-> !out_clk)
        else $error("generator clocked target");
    init_pulse_a: assert property (out_clk && init_r |=> !oclk_out && oclk_oe ##1 oclk_out)
        else $error("initiator pulse wrong");
    target_float_a: assert property (!init_r |=> !oclk_oe)
        else $error("target drives pin");
    edge_once_a: assert property (pin_fall |=> !pin_fall)
        else $error("edge event longer than one cycle");
    strobe_clear_a: assert property (swclk_r |=> !swclk_r)
        else $error("strobe did not self clear");
    // Clock source, direct hold, span and pin drive checks
    gen_clock_a: assert property (simul_r && init_r && ratec_en_r && ratec_tick |-> out_clk)
        else $error("generator tick lost");
    pin_clock_a: assert property (simul_r && !init_r && pin_fall |-> out_clk)
        else $error("pin edge lost");
    direct_hold_a: assert property (!simul_r && !wr_ch0 |=> out0_r == $past(out0_r))
        else $error("immediate output changed without write");
    span_write_a: assert property (wr_ctrl |=> span_r == $past(pwdata[`DRDAC_CTL_RANGE_HI:`DRDAC_CTL_RANGE_LO]))
        else $error("span field not stored");
    init_drive_a: assert property (init_r |=> oclk_oe)
        else $error("initiator does not drive pin");
    pulse_end_a: assert property (pulse_cnt_r == 2'h1 && !(out_clk && init_r) |=> oclk_out)
        else $error("pin pulse too long");

    // Main scenarios seen at least once
    joint_update_c: cover property (out_clk ##1 out0_r != $past(out0_r));
    ext_edge_c: cover property (ext_clk && simul_r);
    init_pulse_c: cover property (gen_clk && simul_r);
    buf_mode_c: cover property (bufsel_r && wr_ch0);
    sw_strobe_c: cover property (swclk_r && simul_r);
endmodule

// >>> verif/drdac_peer.sv
// Peer board model sitting on the shared output clock line.
// Assumes the line is pulled up whenever nobody pulls it low.
`timescale 1ns/1ps
module drdac_peer
(
    // Shared line and pulse command
    input wire logic line,
    input wire logic fire,
    // Drive toward the line and edge count
    output logic peer_oe,
    output logic peer_out,
    output int falls
);
    // Released by default so the pull-up sets the level
    initial
    begin
        peer_oe = 1'b0;
        peer_out = 1'b1;
        falls = 0;
    end
    // Initiator pulse, deliberately off the target's clock phase
    always @(posedge fire)
    begin
        #37;
        peer_oe = 1'b1;
        peer_out = 1'b0;
        #300;
        peer_oe = 1'b0;
        peer_out = 1'b1;
    end
    // Count high-to-low changes seen on the line
    always @(negedge line)
        falls++;
endmodule

// >>> verif/tb_direct_register_dac_update.sv
// Self-checking bench for the direct-register output update block.
// Assumes the design constants header and the peer model compile first.
`timescale 1ns/1ps
`include "drdac_params.svh"
module tb_direct_register_dac_update
    import drdac_pkg::*;
;
    logic sys_clk, reset, psel, penable, pwrite, ratec_tick, fire, er;
    logic pready, pslverr, oclk_out, oclk_oe, out_clk_event, peer_oe, peer_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] buf_code0, buf_code1;
    drdac_aout_t aout;
    int errors, tests_run, n_ev, n_low, falls, f0;
    typedef struct {logic [11:0] a; logic [31:0] d; drdac_aout_t q;} drdac_row_t;
    drdac_row_t rows [5] = '{'{12'h008, 32'hffff1234, '{16'h1234, 16'h8000, DRDAC_SPAN_10V}},
        '{12'h00c, 32'habcd0001, '{16'h1234, 16'h0001, DRDAC_SPAN_10V}},
        '{12'h000, 32'h00000010, '{16'h1234, 16'h0001, DRDAC_SPAN_5V}},
        '{12'h000, 32'h00000020, '{16'h1234, 16'h0001, DRDAC_SPAN_2V5}},
        '{12'h000, 32'h00000000, '{16'h1234, 16'h0001, DRDAC_SPAN_10V}}};
    // Pulled-up shared line: low while any party drives low
    wire oclk_line = ((oclk_oe & ~oclk_out) | (peer_oe & ~peer_out)) ? 1'b0 : 1'b1;
    // ----------------------------------------
    // Design and peer
    // ----------------------------------------
    drdac_core uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ratec_tick(ratec_tick), .buf_code0(buf_code0), .buf_code1(buf_code1), .oclk_in(oclk_line),
        .oclk_out(oclk_out), .oclk_oe(oclk_oe), .aout(aout), .out_clk_event(out_clk_event));
    drdac_peer peer (.line(oclk_line), .fire(fire), .peer_oe(peer_oe), .peer_out(peer_out), .falls(falls));
    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        #(3000 * 100);
        errors++;
        results();
    end
    // Mid-cycle sampling keeps the count clear of edge races
    always @(negedge sys_clk)
    begin
        if (out_clk_event === 1'b1) n_ev++;
        if (oclk_oe === 1'b1 && oclk_out === 1'b0) n_low++;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task results();
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [33:0] s, input logic [33:0] e);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer; waits on pready, a hang is left to the watchdog
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task tick();
        @(posedge sys_clk);
        ratec_tick <= 1'b1;
        @(posedge sys_clk);
        ratec_tick <= 1'b0;
        wt(4);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ratec_tick, fire} = '0;
        {buf_code0, buf_code1} = {16'h4321, 16'h8765};
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        wt(1);
        chk(aout, {16'h8000, 16'h8000, 2'h0});
        apb(1'b0, `DRDAC_OFF_CH0, 32'h0);
        chk(rd, 32'h8000);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            wt(2);
            chk(aout, rows[i].q);
        end
        // Joint mode: writes are held until a strobe
        apb(1'b1, `DRDAC_OFF_CTRL, 32'h2);
        apb(1'b1, `DRDAC_OFF_CH0, 32'h5555);
        apb(1'b1, `DRDAC_OFF_CH1, 32'haaaa);
        wt(4);
        chk(aout, {16'h1234, 16'h0001, 2'h0});
        apb(1'b1, `DRDAC_OFF_CTRL, 32'h6);
        wt(5);
        chk(aout, {16'h5555, 16'haaaa, 2'h0});
        chk(n_ev, 1);
        apb(1'b0, `DRDAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h2);
        // Initiator: strobe gives one low pin pulse
        f0 = falls;
        apb(1'b1, `DRDAC_OFF_BOW, 32'h1);
        apb(1'b1, `DRDAC_OFF_CH0, 32'h0111);
        apb(1'b1, `DRDAC_OFF_CTRL, 32'h6);
        wt(5);
        chk(n_low, 1);
        chk(falls, f0 + 1);
        chk(oclk_oe, 1'b1);
        chk(aout.code0, 16'h0111);
        apb(1'b0, `DRDAC_OFF_STAT, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, `DRDAC_OFF_BOW, 32'h0);
        chk(rd, 32'h1);
        // Rate generator gated by enable and role
        apb(1'b1, `DRDAC_OFF_CTRL, 32'ha);
        apb(1'b1, `DRDAC_OFF_CH0, 32'h0222);
        tick();
        chk(aout.code0, 16'h0222);
        apb(1'b1, `DRDAC_OFF_CTRL, 32'h2);
        apb(1'b1, `DRDAC_OFF_CH0, 32'h0333);
        tick();
        chk(aout.code0, 16'h0222);
        apb(1'b1, `DRDAC_OFF_BOW, 32'h0);
        apb(1'b1, `DRDAC_OFF_CTRL, 32'ha);
        tick();
        chk(aout.code0, 16'h0222);
        chk(oclk_oe, 1'b0);
        // Target: one peer falling edge loads once
        @(posedge sys_clk);
        fire <= 1'b1;
        wt(12);
        fire <= 1'b0;
        chk(aout.code0, 16'h0333);
        chk(n_ev, 4);
        // Buffered path owns the outputs
        apb(1'b1, `DRDAC_OFF_CTRL, 32'h1);
        apb(1'b1, `DRDAC_OFF_CH0, 32'h0999);
        wt(4);
        chk(aout.code0, 16'h4321);
        chk(aout.code1, 16'h8765);
        apb(1'b0, 12'h100, 32'h0);
        chk({rd, er}, {32'h0, 1'b1});
        // Second reset in mid-run
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wt(1);
        chk(aout, {16'h8000, 16'h8000, 2'h0});
        chk({oclk_oe, oclk_out}, 2'b01);
        results();
    end
endmodule
